// [power_seq_pkg.sv]
// Constants, register map and carrier types for the power output and panel sequencer.
// Assumes a 250 MHz core clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package power_seq_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_US = 500;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int DELAY_W = 9;
  localparam int BOOT_DELAY_US = 250000;
  localparam int RESUME_DELAY_0_US = 250000;
  localparam int RESUME_DELAY_1_US = 125000;
  localparam int RESUME_DELAY_2_US = 62500;
  localparam int RESUME_DELAY_3_US = 0;
  localparam int PANEL_STEP_0_US = 10000;
  localparam int PANEL_STEP_1_US = 30000;
  localparam int PANEL_STEP_2_US = 60000;
  localparam int PANEL_STEP_3_US = 90000;
  localparam logic [DELAY_W-1:0] BOOT_TICKS = DELAY_W'(BOOT_DELAY_US / TICK_PERIOD_US);
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_ON_PWR = 12'h0C6;
  localparam logic [11:0] IDX_DOZE_PWR = 12'h0C7;
  localparam logic [11:0] IDX_SLEEP_PWR = 12'h0C8;
  localparam logic [11:0] IDX_SUSPEND_PWR = 12'h0C9;
  localparam logic [11:0] IDX_POLARITY = 12'h0CA;
  localparam logic [11:0] IDX_OUTPUT = 12'h0CB;
  localparam logic [11:0] IDX_PANEL_MODE = 12'h0D0;
  localparam logic [11:0] IDX_STATUS = 12'h0D1;
  localparam logic [11:0] IDX_RESUME = 12'h0DD;
  // Field positions
  localparam int BIT_RAM_SUPPLY = 7;
  localparam int BIT_SYS_SUPPLY = 2;
  localparam int BIT_PANEL_POWER = 1;
  localparam int BIT_LOGIC_POL = 0;
  localparam int BIT_PANEL_BIAS_POLARITY = 1;
  localparam int BIT_SEQ_UP = 0;
  localparam int BIT_SEQ_DN = 1;
  localparam int LSB_SEQ_DLY = 2;
  // Values after reset
  localparam logic [7:0] RST_ON_PWR = 8'h86;
  localparam logic [7:0] RST_DOZE_PWR = 8'h86;
  localparam logic [7:0] RST_SLEEP_PWR = 8'h84;
  localparam logic [7:0] RST_SUSPEND_PWR = 8'h80;
  localparam logic [7:0] RST_POLARITY = 8'h03;
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [7:0] RST_PANEL_MODE = 8'h00;
  localparam logic [7:0] RST_RESUME = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PM_ON = 3'b000, PM_DOZE = 3'b001, PM_SLEEP = 3'b010, PM_SUSPEND = 3'b011, PM_OFF = 3'b100
  } pm_state_type;

  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_type;
endpackage : power_seq_pkg
`default_nettype wire

// [delay_timer.sv]
// Delay timer counting fixed half-millisecond ticks of the core clock.
// Assumes a single clock; a start pulse restarts the count from i_load.
`default_nettype none
module delay_timer #(
  parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES,
  parameter int DELAY_W     = power_seq_pkg::DELAY_W
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_start,
  input  wire logic [DELAY_W-1:0] i_load,
  output logic                    o_done
);
  if (TICK_CYCLES < 2 || DELAY_W < 1) begin : g_bad_params
    $error("delay_timer: bad parameters");
  end

  logic [31:0]        pre_reg, pre_next;
  logic [DELAY_W-1:0] count_reg, count_next;
  logic               busy_reg, busy_next;
  logic               done_reg, done_next;

  // Ticks come from a prescaler so durations do not depend on CPU speed
  always_comb begin
    pre_next = pre_reg;
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (i_start) begin
      pre_next = 32'h0;
      count_next = i_load;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (count_reg == '0) begin
        done_next = 1'b1;
        busy_next = 1'b0;
      end else if (pre_reg == 32'(TICK_CYCLES - 1)) begin
        pre_next = 32'h0;
        count_next = count_reg - 1'b1;
      end else begin
        pre_next = pre_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= 32'h0;
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule : delay_timer
`default_nettype wire

// [power_output_and_panel_sequencer.sv]
// Power output and panel sequencer: supply enables, resume delay, panel power sequencing.
// Assumes the power manager state arrives on the core clock; power good is an async pin.
// Functional notes
// - System and RAM enables are fixed active high
// - Polarity bit D0 sets panel logic enable polarity
// - Panel enables float after hard reset
// - RAM follows D7, system follows D2
// - OFF state forces system and RAM low
// - One power register per non-off state
// - Cleared doze panel bit turns panel off
// - System pins float until power good
// - Boot waits fixed 250 ms after power good
// - Resume delay selectable 250/125/62.5/0 ms
// - Panel enables come from panel sequencer only
// - Polarity bit 1 active high, 0 low
// - Panel enables driven only while panel powered
// - Sequenced up: logic, wait, signals, wait, bias
// - Unsequenced up: everything switches at once
// - Sequenced down: bias, signals, logic, same delay
// - Suspend does not wait for panel power-down done; it is reported on O_PANEL_DOWN_DONE and in the status panel state field
// - Sequenced power-down takes 20 to 180 ms
// - System enable asserted at resume start
`default_nettype none
module power_output_and_panel_sequencer #(
  parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic [2:0]  I_PM_STATE,
  input  wire logic        I_SYSTEM_POWER_GOOD,
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic             O_SYSTEM_SUPPLY_ENABLE,
  output logic             O_RAM_SUPPLY_ENABLE,
  output logic             O_SYSTEM_PINS_OE_N,
  output logic             O_EXECUTION_ENABLE,
  output logic             O_PANEL_LOGIC_SUPPLY_ENABLE,
  output logic             O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N,
  output logic             O_PANEL_BIAS_SUPPLY_ENABLE,
  output logic             O_PANEL_BIAS_SUPPLY_ENABLE_OE_N,
  output logic             O_PANEL_SIGNALS_ENABLE,
  output logic             O_PANEL_DOWN_DONE
);
  localparam int DW = power_seq_pkg::DELAY_W;

  typedef enum logic [1:0] {
    EX_WAIT_PG = 2'b00, EX_DELAY = 2'b01, EX_RUN = 2'b10, EX_PARKED = 2'b11
  } exec_state_type;

  typedef enum logic [2:0] {
    PN_OFF = 3'b000, PN_UP_LOGIC = 3'b001, PN_UP_SIGNALS = 3'b010, PN_ON = 3'b011,
    PN_DN_BIAS = 3'b100, PN_DN_SIGNALS = 3'b101
  } panel_state_type;

  // Maps a byte address to a register slot, 15 when unmapped
  function automatic logic [3:0] decode(input logic [11:0] addr);
    logic [11:0] idx;
    idx = {2'b00, addr[11:2]};
    if (addr[1:0] != 2'b00) decode = 4'hF;
    else if (idx >= power_seq_pkg::IDX_ON_PWR && idx <= power_seq_pkg::IDX_OUTPUT)
      decode = 4'(idx - power_seq_pkg::IDX_ON_PWR);
    else if (idx == power_seq_pkg::IDX_PANEL_MODE) decode = 4'h6;
    else if (idx == power_seq_pkg::IDX_STATUS) decode = 4'h7;
    else if (idx == power_seq_pkg::IDX_RESUME) decode = 4'h8;
    else decode = 4'hF;
  endfunction : decode

  // Half-millisecond ticks for a two-bit resume delay choice
  function automatic logic [DW-1:0] resume_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: resume_ticks = DW'(power_seq_pkg::RESUME_DELAY_0_US / power_seq_pkg::TICK_PERIOD_US);
      2'h1: resume_ticks = DW'(power_seq_pkg::RESUME_DELAY_1_US / power_seq_pkg::TICK_PERIOD_US);
      2'h2: resume_ticks = DW'(power_seq_pkg::RESUME_DELAY_2_US / power_seq_pkg::TICK_PERIOD_US);
      default: resume_ticks = DW'(power_seq_pkg::RESUME_DELAY_3_US / power_seq_pkg::TICK_PERIOD_US);
    endcase
  endfunction : resume_ticks

  function automatic logic [DW-1:0] step_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: step_ticks = DW'(power_seq_pkg::PANEL_STEP_0_US / power_seq_pkg::TICK_PERIOD_US);
      2'h1: step_ticks = DW'(power_seq_pkg::PANEL_STEP_1_US / power_seq_pkg::TICK_PERIOD_US);
      2'h2: step_ticks = DW'(power_seq_pkg::PANEL_STEP_2_US / power_seq_pkg::TICK_PERIOD_US);
      default: step_ticks = DW'(power_seq_pkg::PANEL_STEP_3_US / power_seq_pkg::TICK_PERIOD_US);
    endcase
  endfunction : step_ticks

  // Power good synchroniser
  logic pg_meta_reg, pg_sync_reg;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
    end else begin
      pg_meta_reg <= I_SYSTEM_POWER_GOOD;
      pg_sync_reg <= pg_meta_reg;
    end
  end

  // Register file and AXI4-Lite slave
  logic [7:0]  pwr_reg [4];
  logic [7:0]  pwr_next [4];
  logic [7:0]  pol_reg, pol_next, out_reg, out_next;
  logic [7:0]  mode_reg, mode_next, resume_reg, resume_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        wstrb0_reg, wstrb0_next;
  logic        have_aw_reg, have_aw_next, have_w_reg, have_w_next;
  logic        bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  status;
  logic [3:0]  wslot, rslot;
  exec_state_type  ex_reg, ex_next;
  panel_state_type pn_reg, pn_next;

  always_comb begin
    pwr_next = pwr_reg;
    pol_next = pol_reg;
    out_next = out_reg;
    mode_next = mode_reg;
    resume_next = resume_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    have_aw_next = have_aw_reg;
    have_w_next = have_w_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    wslot = decode(awaddr_reg);
    rslot = decode(I_ARADDR);
    if (I_AWVALID && !have_aw_reg) begin
      awaddr_next = I_AWADDR;
      have_aw_next = 1'b1;
    end
    if (I_WVALID && !have_w_reg) begin
      wdata_next = I_WDATA;
      wstrb0_next = I_WSTRB[0];
      have_w_next = 1'b1;
    end
    if (bvalid_reg && I_BREADY) bvalid_next = 1'b0;
    if (have_aw_reg && have_w_reg && !bvalid_reg) begin
      have_aw_next = 1'b0;
      have_w_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wslot == 4'hF) ? power_seq_pkg::RESP_SLVERR : power_seq_pkg::RESP_OKAY;
      if (wstrb0_reg) begin
        case (wslot)
          4'h0, 4'h1, 4'h2, 4'h3: pwr_next[wslot[1:0]] = wdata_reg[7:0];
          4'h4: pol_next = wdata_reg[7:0];
          4'h5: out_next = wdata_reg[7:0];
          4'h6: mode_next = wdata_reg[7:0];
          4'h8: resume_next = {6'h00, wdata_reg[1:0]};
          default: ;
        endcase
      end
    end
    if (rvalid_reg && I_RREADY) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    if (I_ARVALID && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = (rslot == 4'hF) ? power_seq_pkg::RESP_SLVERR : power_seq_pkg::RESP_OKAY;
      case (rslot)
        4'h0, 4'h1, 4'h2, 4'h3: rdata_next = {24'h0, pwr_reg[rslot[1:0]]};
        4'h4: rdata_next = {24'h0, pol_reg};
        4'h5: rdata_next = {24'h0, out_reg};
        4'h6: rdata_next = {24'h0, mode_reg};
        4'h7: rdata_next = {24'h0, status};
        4'h8: rdata_next = {24'h0, resume_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pwr_reg[0] <= power_seq_pkg::RST_ON_PWR;
      pwr_reg[1] <= power_seq_pkg::RST_DOZE_PWR;
      pwr_reg[2] <= power_seq_pkg::RST_SLEEP_PWR;
      pwr_reg[3] <= power_seq_pkg::RST_SUSPEND_PWR;
      pol_reg <= power_seq_pkg::RST_POLARITY;
      out_reg <= power_seq_pkg::RST_OUTPUT;
      mode_reg <= power_seq_pkg::RST_PANEL_MODE;
      resume_reg <= power_seq_pkg::RST_RESUME;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= power_seq_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= power_seq_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      pwr_reg <= pwr_next;
      pol_reg <= pol_next;
      out_reg <= out_next;
      mode_reg <= mode_next;
      resume_reg <= resume_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      have_aw_reg <= have_aw_next;
      have_w_reg <= have_w_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign O_AWREADY = ~have_aw_reg;
  assign O_WREADY = ~have_w_reg;
  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;
  assign O_ARREADY = arready_reg;
  assign O_RVALID = rvalid_reg;
  assign O_RRESP = rresp_reg;
  assign O_RDATA = rdata_reg;

  // Execution gate: wait for power good, then the boot or resume delay
  logic          pm_off, pm_low, boot_reg, boot_next, ex_start, ex_done;
  logic [DW-1:0] ex_load;
  logic          exec_out_reg;
  assign pm_off = (I_PM_STATE == power_seq_pkg::PM_OFF);
  assign pm_low = pm_off || (I_PM_STATE == power_seq_pkg::PM_SUSPEND);

  always_comb begin
    ex_next = ex_reg;
    boot_next = boot_reg;
    ex_start = 1'b0;
    ex_load = boot_reg ? power_seq_pkg::BOOT_TICKS : resume_ticks(resume_reg[1:0]);
    case (ex_reg)
      EX_WAIT_PG: begin
        if (pm_low && !boot_reg) ex_next = EX_PARKED;
        else if (pg_sync_reg) begin
          ex_start = 1'b1;
          ex_next = EX_DELAY;
        end
      end
      EX_DELAY: begin
        if (!pg_sync_reg) ex_next = EX_WAIT_PG;
        else if (ex_done) begin
          boot_next = 1'b0;
          ex_next = EX_RUN;
        end
      end
      EX_RUN: if (pm_low) ex_next = EX_PARKED;
      EX_PARKED: if (!pm_low) ex_next = EX_WAIT_PG;
      default: ex_next = EX_WAIT_PG;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ex_reg <= EX_WAIT_PG;
      boot_reg <= 1'b1;
    end else begin
      ex_reg <= ex_next;
      boot_reg <= boot_next;
    end
  end

  delay_timer #(.TICK_CYCLES(TICK_CYCLES), .DELAY_W(DW)) u_exec_timer (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_start (ex_start),
    .i_load  (ex_load),
    .o_done  (ex_done)
  );

  // Panel power sequencing
  logic          panel_req, seq_up, seq_dn, pn_start, pn_done;
  logic [7:0]    cur_pwr;
  logic [DW-1:0] pn_load;
  assign cur_pwr = pm_off ? 8'h00 : pwr_reg[I_PM_STATE[1:0]];
  assign panel_req = cur_pwr[power_seq_pkg::BIT_PANEL_POWER];
  assign seq_up = mode_reg[power_seq_pkg::BIT_SEQ_UP];
  assign seq_dn = mode_reg[power_seq_pkg::BIT_SEQ_DN];
  assign pn_load = step_ticks(mode_reg[power_seq_pkg::LSB_SEQ_DLY +: 2]);

  always_comb begin
    pn_next = pn_reg;
    pn_start = 1'b0;
    case (pn_reg)
      PN_OFF: begin
        if (panel_req && seq_up) begin
          pn_next = PN_UP_LOGIC;
          pn_start = 1'b1;
        end else if (panel_req) pn_next = PN_ON;
      end
      PN_UP_LOGIC: begin
        if (!panel_req) pn_next = PN_OFF;
        else if (pn_done) begin
          pn_next = PN_UP_SIGNALS;
          pn_start = 1'b1;
        end
      end
      PN_UP_SIGNALS: begin
        if (!panel_req) pn_next = PN_OFF;
        else if (pn_done) pn_next = PN_ON;
      end
      PN_ON: begin
        if (!panel_req && seq_dn) begin
          pn_next = PN_DN_BIAS;
          pn_start = 1'b1;
        end else if (!panel_req) pn_next = PN_OFF;
      end
      PN_DN_BIAS: begin
        if (pn_done) begin
          pn_next = PN_DN_SIGNALS;
          pn_start = 1'b1;
        end
      end
      PN_DN_SIGNALS: if (pn_done) pn_next = PN_OFF;
      default: pn_next = PN_OFF;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) pn_reg <= PN_OFF;
    else pn_reg <= pn_next;
  end

  delay_timer #(.TICK_CYCLES(TICK_CYCLES), .DELAY_W(DW)) u_panel_timer (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_start (pn_start),
    .i_load  (pn_load),
    .o_done  (pn_done)
  );

  // Registered pin drives
  power_seq_pkg::pin_drive_type logic_pin_reg, logic_pin_next, bias_pin_reg, bias_pin_next;
  logic sys_en_reg, sys_en_next, ram_en_reg, ram_en_next, sig_reg, sig_next;
  logic pins_oe_n_reg, down_done_reg, down_done_next;

  always_comb begin
    sys_en_next = cur_pwr[power_seq_pkg::BIT_SYS_SUPPLY];
    ram_en_next = cur_pwr[power_seq_pkg::BIT_RAM_SUPPLY];
    logic_pin_next.level = pol_reg[power_seq_pkg::BIT_LOGIC_POL];
    bias_pin_next.level = pol_reg[power_seq_pkg::BIT_PANEL_BIAS_POLARITY];
    logic_pin_next.oe_n = (pn_next == PN_OFF);
    bias_pin_next.oe_n = (pn_next != PN_ON);
    sig_next = (pn_next == PN_UP_SIGNALS) || (pn_next == PN_ON) || (pn_next == PN_DN_BIAS);
    down_done_next = (pn_next == PN_OFF);
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sys_en_reg <= 1'b0;
      ram_en_reg <= 1'b0;
      logic_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
      bias_pin_reg <= '{level: 1'b0, oe_n: 1'b1};
      sig_reg <= 1'b0;
      pins_oe_n_reg <= 1'b1;
      exec_out_reg <= 1'b0;
      down_done_reg <= 1'b1;
    end else begin
      sys_en_reg <= sys_en_next;
      ram_en_reg <= ram_en_next;
      logic_pin_reg <= logic_pin_next;
      bias_pin_reg <= bias_pin_next;
      sig_reg <= sig_next;
      pins_oe_n_reg <= ~pg_sync_reg;
      exec_out_reg <= (ex_next == EX_RUN);
      down_done_reg <= down_done_next;
    end
  end

  assign status = {pn_reg, pg_sync_reg, exec_out_reg, I_PM_STATE};
  assign O_SYSTEM_SUPPLY_ENABLE = sys_en_reg;
  assign O_RAM_SUPPLY_ENABLE = ram_en_reg;
  assign O_SYSTEM_PINS_OE_N = pins_oe_n_reg;
  assign O_EXECUTION_ENABLE = exec_out_reg;
  assign O_PANEL_LOGIC_SUPPLY_ENABLE = logic_pin_reg.level;
  assign O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N = logic_pin_reg.oe_n;
  assign O_PANEL_BIAS_SUPPLY_ENABLE = bias_pin_reg.level;
  assign O_PANEL_BIAS_SUPPLY_ENABLE_OE_N = bias_pin_reg.oe_n;
  assign O_PANEL_SIGNALS_ENABLE = sig_reg;
  assign O_PANEL_DOWN_DONE = down_done_reg;
endmodule : power_output_and_panel_sequencer
`default_nettype wire

// [power_seq_asserts.sv]
// Checker for supply, panel and bus outputs of the power sequencer.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module power_seq_asserts (
  input wire logic        I_CLK,
  input wire logic        I_SYS_RST,
  input wire logic [2:0]  I_PM_STATE,
  input wire logic        I_SYSTEM_POWER_GOOD,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_BVALID,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_SYSTEM_SUPPLY_ENABLE,
  input wire logic        O_RAM_SUPPLY_ENABLE,
  input wire logic        O_SYSTEM_PINS_OE_N,
  input wire logic        O_EXECUTION_ENABLE,
  input wire logic        O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N,
  input wire logic        O_PANEL_BIAS_SUPPLY_ENABLE_OE_N,
  input wire logic        O_PANEL_SIGNALS_ENABLE,
  input wire logic        O_PANEL_DOWN_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_off_supplies_low: assert property (I_PM_STATE == 3'h4 [*2] |=>
    !O_SYSTEM_SUPPLY_ENABLE && !O_RAM_SUPPLY_ENABLE) else $error("supply on in off state");
  a_pins_float_nopg: assert property (!I_SYSTEM_POWER_GOOD [*5] |->
    O_SYSTEM_PINS_OE_N) else $error("system pins driven without power good");
  a_exec_needs_pg: assert property (!I_SYSTEM_POWER_GOOD [*5] |->
    !O_EXECUTION_ENABLE) else $error("execution without power good");
  a_signals_need_logic: assert property (O_PANEL_SIGNALS_ENABLE |->
    !O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N) else $error("panel signals without logic supply");
  a_bias_needs_signals: assert property (!O_PANEL_BIAS_SUPPLY_ENABLE_OE_N |->
    O_PANEL_SIGNALS_ENABLE) else $error("bias driven without panel signals");
  a_done_all_float: assert property (O_PANEL_DOWN_DONE |-> O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N
    && O_PANEL_BIAS_SUPPLY_ENABLE_OE_N && !O_PANEL_SIGNALS_ENABLE) else $error("done not off");
  a_bvalid_holds: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
  a_rvalid_holds: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read data dropped");
endmodule : power_seq_asserts
`default_nettype wire

// [supply_model.sv]
// Supply switch, supervisor and panel pull resistor model.
// Assumes enables arrive on the core clock.
`default_nettype none
module supply_model #(
  parameter int   PG_DELAY = 16,
  parameter logic PULL     = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_supply_on,
  input  wire logic i_logic_level,
  input  wire logic i_logic_oe_n,
  output logic      o_power_good,
  output logic      o_logic_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp = 0;
  always @(posedge i_clk) begin
    ramp <= !i_supply_on ? 0 : (ramp < PG_DELAY) ? ramp + 1 : ramp;
  end
  assign o_power_good = i_supply_on && ramp == PG_DELAY;
  assign o_logic_wire = i_logic_oe_n ? PULL : i_logic_level;
endmodule : supply_model
`default_nettype wire

// [power_output_and_panel_sequencer_tb.sv]
// Self-checking bench for the power output and panel sequencer.
// Assumes a four-cycle tick so long delays fit a short run.
`default_nettype none
module power_output_and_panel_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [2:0]  st = 3'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic        awready, wready, bvalid, arready, rvalid, pg, sys_en, ram_en, pins_oe_n, exec;
  logic        lg, lg_oe_n, bs, bs_oe_n, sig_en, dn_done, lg_wire;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rv [6] = '{8'h86, 8'h86, 8'h84, 8'h80, 8'h03, 8'h00};
  int          stp [4] = '{20, 60, 120, 180};
  int          errors = 0, checks = 0, cyc = 0, t0 = 0, n, i, d, t;
  always #2 clk = ~clk;
  always @(posedge pg) t0 = cyc;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  power_output_and_panel_sequencer #(.TICK_CYCLES(TK)) u_power_output_and_panel_sequencer (
    .I_CLK(clk), .I_SYS_RST(rst), .I_PM_STATE(st), .I_SYSTEM_POWER_GOOD(pg),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_SYSTEM_SUPPLY_ENABLE(sys_en), .O_RAM_SUPPLY_ENABLE(ram_en),
    .O_SYSTEM_PINS_OE_N(pins_oe_n), .O_EXECUTION_ENABLE(exec),
    .O_PANEL_LOGIC_SUPPLY_ENABLE(lg), .O_PANEL_LOGIC_SUPPLY_ENABLE_OE_N(lg_oe_n),
    .O_PANEL_BIAS_SUPPLY_ENABLE(bs), .O_PANEL_BIAS_SUPPLY_ENABLE_OE_N(bs_oe_n),
    .O_PANEL_SIGNALS_ENABLE(sig_en), .O_PANEL_DOWN_DONE(dn_done));
  supply_model u_supply_model (.i_clk(clk), .i_supply_on(sys_en), .i_logic_level(lg),
    .i_logic_oe_n(lg_oe_n), .o_power_good(pg), .o_logic_wire(lg_wire));
  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rng(input string nm, input int v, input int lo);
    chk(nm, 1, v >= lo && v <= lo + 12);
  endtask : rng
  function logic [11:0] ba(input logic [11:0] idx);
    return idx << 2;
  endfunction : ba
  function logic pick(input int s);
    case (s)
      0: return exec;
      1: return sig_en;
      2: return bs_oe_n;
      3: return dn_done;
      default: return lg_oe_n;
    endcase
  endfunction : pick
  task till(input int s, input logic v);
    do begin
      @(negedge clk);
    end while (pick(s) !== v);
    @(posedge clk);
  endtask : till
  task wr(input logic [11:0] a, input logic [31:0] dt);
    logic ta, tw, tb;
    awaddr <= a; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid;
      if (tb) chk("bresp", power_seq_pkg::RESP_OKAY, bresp);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid & arready; tr = rvalid;
      if (tr) chk("rdata", e, rdata);
      if (tr) chk("rresp", er, rresp);
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  initial begin
    n = $urandom(32'h966BFF29);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("panel float", 3'b110, {lg_oe_n, bs_oe_n, lg_wire});
    chk("pins float", 1, pins_oe_n);
    @(posedge clk);
    for (i = 0; i < 6; i++) rd(ba(12'h0C6 + 12'(i)), rv[i], power_seq_pkg::RESP_OKAY);
    rd(12'h004, 0, power_seq_pkg::RESP_SLVERR);
    wr(ba(power_seq_pkg::IDX_RESUME), 3);
    till(0, 1'b1);
    rng("boot delay", cyc - t0, 500 * TK);
    chk("pins driven", 0, pins_oe_n);
    rd(ba(power_seq_pkg::IDX_STATUS), 32'h78, power_seq_pkg::RESP_OKAY);
    $display("test boot done");
    for (i = 0; i < 5; i++) begin
      d = $urandom | (i < 3 ? 4 : 0);
      if (i < 4) wr(ba(12'h0C6 + 12'(i)), d);
      st <= 3'(i);
      repeat (3) @(negedge clk);
      chk("ram enable", i < 4 && d[7], ram_en);
      chk("system enable", i < 4 && d[2], sys_en);
      @(posedge clk);
    end
    for (i = 0; i < 4; i++) wr(ba(12'h0C6 + 12'(i)), rv[i]);
    st <= 3'h3;
    repeat (30) @(posedge clk);
    d = $urandom % 4;
    wr(ba(power_seq_pkg::IDX_RESUME), d);
    st <= 3'h0;
    repeat (3) @(negedge clk);
    chk("resume start", 2'b10, {sys_en, pg});
    till(0, 1'b1);
    rng("resume delay", cyc - t0, (d == 3 ? 0 : 500 >> d) * TK);
    $display("test supplies done");
    d = $urandom % 4;
    wr(ba(power_seq_pkg::IDX_POLARITY), d);
    repeat (3) @(negedge clk);
    chk("panel on", {d[1:0], 3'b001}, {bs, lg, bs_oe_n, lg_oe_n, sig_en});
    wr(ba(power_seq_pkg::IDX_DOZE_PWR), 8'h84);
    st <= 3'h1;
    repeat (3) @(negedge clk);
    chk("doze off", 4'b1101, {bs_oe_n, lg_oe_n, sig_en, dn_done});
    @(posedge clk);
    d = $urandom % 4;
    wr(ba(power_seq_pkg::IDX_PANEL_MODE), 3 | (d << 2));
    st <= 3'h0;
    till(4, 1'b0);
    t = cyc;
    till(1, 1'b1);
    rng("up step one", cyc - t, stp[d] * TK);
    t = cyc;
    till(2, 1'b0);
    rng("up step two", cyc - t, stp[d] * TK);
    st <= 3'h1;
    t = cyc;
    repeat (4) @(negedge clk);
    chk("down bias first", 3'b110, {bs_oe_n, sig_en, dn_done});
    till(3, 1'b1);
    rng("down total", cyc - t, 2 * stp[d] * TK);
    $display("test panel done");
    results();
  end
endmodule : power_output_and_panel_sequencer_tb
bind power_output_and_panel_sequencer power_seq_asserts u_power_seq_asserts (.*);
`default_nettype wire
